// *** osp_pkg.sv ***
// constants for the output synchronisation parameter bank
package osp_pkg;
    // register indices on the plain register port
    localparam logic [5:0] OSP_IDX_PARAM_COUNT = 6'h00;
    localparam logic [5:0] OSP_IDX_MODE = 6'h01;
    localparam logic [5:0] OSP_IDX_CYCLE = 6'h02;
    localparam logic [5:0] OSP_IDX_SHIFT = 6'h03;
    localparam logic [5:0] OSP_IDX_CAPAB = 6'h04;
    localparam logic [5:0] OSP_IDX_MIN_CYCLE = 6'h05;
    localparam logic [5:0] OSP_IDX_CALC_COPY = 6'h06;
    localparam logic [5:0] OSP_IDX_COMMAND = 6'h08;
    localparam logic [5:0] OSP_IDX_DELAY = 6'h09;
    localparam logic [5:0] OSP_IDX_MISSED = 6'h0b;
    localparam logic [5:0] OSP_IDX_EXCEEDED = 6'h0c;
    localparam logic [5:0] OSP_IDX_SHORT = 6'h0d;
    localparam logic [5:0] OSP_IDX_SYNC_ERR = 6'h20;
    localparam logic [5:0] OSP_IDX_IN_ASSIGN_CNT = 6'h21;
    localparam logic [5:0] OSP_IDX_IN_ASSIGN_ENTRY = 6'h22;
    localparam logic [5:0] OSP_IDX_IN_SHIFT = 6'h23;
    localparam logic [5:0] OSP_IDX_IN_CALC_COPY = 6'h24;
    localparam logic [5:0] OSP_IDX_IN_DELAY = 6'h25;
    localparam logic [5:0] OSP_IDX_IRQ_STATUS = 6'h30;
    localparam logic [5:0] OSP_IDX_IRQ_MASK = 6'h31;

    // reset values
    localparam logic [7:0] OSP_PARAM_COUNT = 8'h20;
    localparam logic [15:0] OSP_CAPAB_BASE = 16'h8007;
    localparam logic [15:0] OSP_CAPAB_SYNC1_SHIFT = 16'h0010;
    localparam logic [15:0] OSP_CAPAB_DYN_TIMES = 16'h4000;
    localparam logic [7:0] OSP_IN_ASSIGN_CNT_RST = 8'h01;
    localparam logic [15:0] OSP_IN_ASSIGN_ENTRY_RST = 16'h1a01;

    // sync mode codes
    localparam logic [15:0] OSP_MODE_FREE_RUN = 16'h0000;
    localparam logic [15:0] OSP_MODE_SM_EVENT = 16'h0001;
    localparam logic [15:0] OSP_MODE_DC_SYNC0 = 16'h0002;
    localparam logic [15:0] OSP_MODE_DC_SYNC1 = 16'h0003;

    // command codes
    localparam logic [15:0] OSP_CMD_STOP = 16'h0000;
    localparam logic [15:0] OSP_CMD_START = 16'h0001;

    // interrupt status bit positions
    localparam int OSP_IRQ_MISSED = 0;
    localparam int OSP_IRQ_EXCEEDED = 1;
    localparam int OSP_IRQ_SHORT = 2;
    localparam int OSP_IRQ_SYNC_ERR = 3;
    localparam int OSP_IRQ_DRIVEN = 4;
    localparam int OSP_IRQ_W = 5;

    // clock period, used to turn cycle counts into nanoseconds
    localparam int OSP_CLK_PERIOD_NS = 5;
    localparam logic [34:0] OSP_CLK_NS_W = 35'(OSP_CLK_PERIOD_NS);
endpackage

// *** osp_bank.sv ***
// output synchronisation parameter bank with timing, measurement and error counters
//
// Function
// - 16-bit mode selector: 0 free run, 1 SM2 event, 2 SYNC0, 3 SYNC1.
// - cycle time in ns: local timer period, master cycle, or SYNC period.
// - in DC mode outputs are driven a shift time after SYNC0.
// - capability word: bit0 free run, bit1 SM2, bits3:2=01 DC; default 0x8007.
// - capability bits5:4=01 for SYNC1 shift, bit14 for dynamic time measurement.
// - minimum sustainable cycle time reported read-only in ns.
// - minimum SYNC0 to SYNC1 spacing reported read-only in ns.
// - command 1 starts local cycle time measurement, 0 stops it.
// - while measuring, shift, min cycle, calc-copy, delay of both sets take maxima.
// - a fresh measurement start clears previously recorded maxima.
// - delay from SYNC1 to outputs driven reported read-only, DC mode only.
// - 16-bit counter of missed SM events in operational state, DC mode.
// - 16-bit cycle exceeded counter: late finish or early next cycle, operational.
// - 16-bit counter of too-short SYNC0 to SYNC1 intervals, DC mode only.
// - sync error flag set when outputs driven too late, DC mode; reset or a drive in DC mode clears it.
// - input assignment holds one entry, default 0x1a01.
// - parameter group reports highest sub-entry number 0x20, read-only.
`timescale 1ns/1ps
module osp_bank #(
    parameter bit SYNC1_SHIFT_EN = 1'b0,
    parameter bit DYN_TIMES_EN = 1'b0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [5:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [31:0] rd_data_o,
    // sync events and state from the device
    input wire logic sm_event_i,
    input wire logic sync0_i,
    input wire logic sync1_i,
    input wire logic op_state_i,
    input wire logic cycle_done_i,
    input wire logic input_latch_i,
    input wire logic input_ready_i,
    // outputs
    output logic drive_outputs_o,
    output logic irq_o
);
    import osp_pkg::*;

    typedef struct packed {
        logic [15:0] mode;
        logic [31:0] cycle;
        logic [31:0] shift;
        logic [31:0] min_cycle;
        logic [31:0] calc_copy;
        logic [15:0] command;
        logic [31:0] delay;
        logic [15:0] missed;
        logic [15:0] exceeded;
        logic [15:0] short_cnt;
        logic sync_err;
        logic [7:0] in_cnt;
        logic [15:0] in_entry;
        logic [31:0] in_shift;
        logic [31:0] in_calc;
        logic [31:0] in_delay;
        logic [OSP_IRQ_W-1:0] irq_stat;
        logic [OSP_IRQ_W-1:0] irq_mask;
        logic irq;
        logic [31:0] rd_data;
        logic drive;
        logic [31:0] fr_cnt;
        logic [31:0] s0_cnt;
        logic [31:0] s1_cnt;
        logic [31:0] trig_cnt;
        logic [31:0] latch_cnt;
        logic pend;
        logic busy;
        logic sm_seen;
    } osp_state_t;

    osp_state_t state_reg;
    osp_state_t state_next;

    // cycle count to ns; saturates so long gaps never wrap into short ones
    function automatic logic [31:0] osp_to_ns(input logic [31:0] cyc);
        logic [34:0] p;
        p = {3'h0, cyc} * OSP_CLK_NS_W;
        return (p[34:32] != 3'h0) ? 32'hffffffff : p[31:0];
    endfunction

    function automatic logic [31:0] osp_inc32(input logic [31:0] v);
        return (v == 32'hffffffff) ? v : v + 32'h1;
    endfunction

    function automatic logic [15:0] osp_sat16(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h1;
    endfunction

    function automatic logic [31:0] osp_max(input logic [31:0] a, input logic [31:0] b);
        return (a > b) ? a : b;
    endfunction

    logic [15:0] capab;
    logic is_dc;
    logic measuring;
    logic trigger;
    logic fr_tick;
    logic shift_ok;
    logic start_meas;
    logic [OSP_IRQ_W-1:0] ev;

    // capability word is built from the feature parameters
    assign capab = OSP_CAPAB_BASE
        | (SYNC1_SHIFT_EN ? OSP_CAPAB_SYNC1_SHIFT : 16'h0000)
        | (DYN_TIMES_EN ? OSP_CAPAB_DYN_TIMES : 16'h0000);

    // mode decode and cycle trigger selection
    always_comb
    begin
        is_dc = (state_reg.mode == OSP_MODE_DC_SYNC0) || (state_reg.mode == OSP_MODE_DC_SYNC1);
        measuring = (state_reg.command == OSP_CMD_START);
        // zero cycle time keeps the free-run timer idle rather than firing every clock
        fr_tick = (state_reg.cycle != 32'h0)
            && (osp_to_ns(osp_inc32(state_reg.fr_cnt)) >= state_reg.cycle);
        case (state_reg.mode)
            OSP_MODE_FREE_RUN: trigger = fr_tick;
            OSP_MODE_SM_EVENT: trigger = sm_event_i;
            OSP_MODE_DC_SYNC0: trigger = sync0_i;
            OSP_MODE_DC_SYNC1: trigger = sync1_i;
            default: trigger = 1'b0;
        endcase
        // shift only delays the outputs in DC mode
        shift_ok = !is_dc || (osp_to_ns(state_reg.s0_cnt) >= state_reg.shift);
        start_meas = wr_en_i && (addr_i == OSP_IDX_COMMAND)
            && (wr_data_i[15:0] == OSP_CMD_START) && !measuring;
    end

    // next state
    always_comb
    begin
        state_next = state_reg;
        ev = '0;
        state_next.drive = 1'b0;

        // elapsed-time counters
        state_next.fr_cnt = fr_tick ? 32'h0 : osp_inc32(state_reg.fr_cnt);
        state_next.s0_cnt = sync0_i ? 32'h0 : osp_inc32(state_reg.s0_cnt);
        state_next.s1_cnt = sync1_i ? 32'h0 : osp_inc32(state_reg.s1_cnt);
        state_next.trig_cnt = trigger ? 32'h0 : osp_inc32(state_reg.trig_cnt);
        state_next.latch_cnt = input_latch_i ? 32'h0 : osp_inc32(state_reg.latch_cnt);

        // missed SM event: a SYNC0 arrives with no SM event since the last one
        if (sm_event_i)
        begin
            state_next.sm_seen = 1'b1;
        end
        if (sync0_i)
        begin
            state_next.sm_seen = sm_event_i;
            if (is_dc && op_state_i && !state_reg.sm_seen)
            begin
                state_next.missed = osp_sat16(state_reg.missed);
                ev[OSP_IRQ_MISSED] = 1'b1;
            end
        end

        // drive outputs once processing is done and the shift has elapsed
        if (state_reg.pend && !state_reg.busy && shift_ok)
        begin
            state_next.pend = 1'b0;
            state_next.drive = 1'b1;
            ev[OSP_IRQ_DRIVEN] = 1'b1;
            if (is_dc)
            begin
                state_next.sync_err = 1'b0;
                if (measuring)
                begin
                    state_next.delay = osp_max(state_reg.delay,
                        osp_to_ns(state_reg.s1_cnt));
                end
            end
        end
        if (cycle_done_i)
        begin
            state_next.busy = 1'b0;
            if (measuring)
            begin
                state_next.min_cycle = osp_max(state_reg.min_cycle,
                    osp_to_ns(state_reg.trig_cnt));
                state_next.shift = osp_max(state_reg.shift,
                    osp_to_ns(state_reg.trig_cnt));
            end
        end

        // a new cycle while the previous is unfinished or undriven
        if (trigger)
        begin
            state_next.pend = 1'b1;
            state_next.busy = 1'b1;
            if (state_reg.pend || state_reg.busy)
            begin
                if (op_state_i)
                begin
                    state_next.exceeded = osp_sat16(state_reg.exceeded);
                    ev[OSP_IRQ_EXCEEDED] = 1'b1;
                end
                if (is_dc && state_reg.pend)
                begin
                    state_next.sync_err = 1'b1;
                    ev[OSP_IRQ_SYNC_ERR] = 1'b1;
                end
            end
        end

        // SYNC0 to SYNC1 spacing check against the reported minimum
        if (sync1_i && is_dc)
        begin
            if (osp_to_ns(state_reg.s0_cnt) < state_reg.calc_copy)
            begin
                state_next.short_cnt = osp_sat16(state_reg.short_cnt);
                ev[OSP_IRQ_SHORT] = 1'b1;
            end
            if (measuring)
            begin
                state_next.calc_copy = osp_max(state_reg.calc_copy,
                    osp_to_ns(state_reg.s0_cnt));
            end
        end

        // input-side measured times
        if (measuring && input_latch_i)
        begin
            state_next.in_shift = osp_max(state_reg.in_shift, osp_to_ns(state_reg.s0_cnt));
            state_next.in_delay = osp_max(state_reg.in_delay,
                osp_to_ns(state_reg.s1_cnt));
        end
        if (measuring && input_ready_i)
        begin
            state_next.in_calc = osp_max(state_reg.in_calc,
                osp_to_ns(state_reg.latch_cnt));
        end

        // register writes
        if (wr_en_i)
        begin
            case (addr_i)
                OSP_IDX_MODE: state_next.mode = wr_data_i[15:0];
                OSP_IDX_CYCLE: state_next.cycle = wr_data_i;
                OSP_IDX_SHIFT: state_next.shift = wr_data_i;
                OSP_IDX_COMMAND: state_next.command = wr_data_i[15:0];
                OSP_IDX_IN_ASSIGN_CNT: state_next.in_cnt = wr_data_i[7:0];
                OSP_IDX_IN_ASSIGN_ENTRY: state_next.in_entry = wr_data_i[15:0];
                OSP_IDX_IRQ_MASK: state_next.irq_mask = wr_data_i[OSP_IRQ_W-1:0];
                default: ;
            endcase
        end

        // a fresh start discards old maxima; overrides any update this cycle
        if (start_meas)
        begin
            state_next.shift = 32'h0;
            state_next.min_cycle = 32'h0;
            state_next.calc_copy = 32'h0;
            state_next.delay = 32'h0;
            state_next.in_shift = 32'h0;
            state_next.in_calc = 32'h0;
            state_next.in_delay = 32'h0;
        end

        // sticky status: write one clears, a new event in the same cycle wins
        state_next.irq_stat = state_reg.irq_stat;
        if (wr_en_i && (addr_i == OSP_IDX_IRQ_STATUS))
        begin
            state_next.irq_stat = state_reg.irq_stat & ~wr_data_i[OSP_IRQ_W-1:0];
        end
        state_next.irq_stat = state_next.irq_stat | ev;
        state_next.irq = |(state_next.irq_stat & state_next.irq_mask);

        // read data stands only in the cycle after the strobe
        state_next.rd_data = 32'h0;
        if (rd_en_i)
        begin
            case (addr_i)
                OSP_IDX_PARAM_COUNT: state_next.rd_data = {24'h0, OSP_PARAM_COUNT};
                OSP_IDX_MODE: state_next.rd_data = {16'h0, state_reg.mode};
                OSP_IDX_CYCLE: state_next.rd_data = state_reg.cycle;
                OSP_IDX_SHIFT: state_next.rd_data = state_reg.shift;
                OSP_IDX_CAPAB: state_next.rd_data = {16'h0, capab};
                OSP_IDX_MIN_CYCLE: state_next.rd_data = state_reg.min_cycle;
                OSP_IDX_CALC_COPY: state_next.rd_data = state_reg.calc_copy;
                OSP_IDX_COMMAND: state_next.rd_data = {16'h0, state_reg.command};
                OSP_IDX_DELAY: state_next.rd_data = state_reg.delay;
                OSP_IDX_MISSED: state_next.rd_data = {16'h0, state_reg.missed};
                OSP_IDX_EXCEEDED: state_next.rd_data = {16'h0, state_reg.exceeded};
                OSP_IDX_SHORT: state_next.rd_data = {16'h0, state_reg.short_cnt};
                OSP_IDX_SYNC_ERR: state_next.rd_data = {31'h0, state_reg.sync_err};
                OSP_IDX_IN_ASSIGN_CNT: state_next.rd_data = {24'h0, state_reg.in_cnt};
                OSP_IDX_IN_ASSIGN_ENTRY: state_next.rd_data = {16'h0, state_reg.in_entry};
                OSP_IDX_IN_SHIFT: state_next.rd_data = state_reg.in_shift;
                OSP_IDX_IN_CALC_COPY: state_next.rd_data = state_reg.in_calc;
                OSP_IDX_IN_DELAY: state_next.rd_data = state_reg.in_delay;
                OSP_IDX_IRQ_STATUS: state_next.rd_data = {27'h0, state_reg.irq_stat};
                OSP_IDX_IRQ_MASK: state_next.rd_data = {27'h0, state_reg.irq_mask};
                default: state_next.rd_data = 32'h0;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_reg <= '0;
            state_reg.in_cnt <= OSP_IN_ASSIGN_CNT_RST;
            state_reg.in_entry <= OSP_IN_ASSIGN_ENTRY_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign rd_data_o = state_reg.rd_data;
    assign drive_outputs_o = state_reg.drive;
    assign irq_o = state_reg.irq;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    chk_mode_write: assert property (
        wr_en_i && addr_i == OSP_IDX_MODE |=> state_reg.mode == $past(wr_data_i[15:0]))
        else $error("mode write not stored");
    chk_capab_read: assert property (
        rd_en_i && addr_i == OSP_IDX_CAPAB |=> rd_data_o[15:0] == capab && capab[3:0] == 4'h7)
        else $error("capability word wrong");
    chk_count_read: assert property (
        rd_en_i && addr_i == OSP_IDX_PARAM_COUNT |=> rd_data_o == 32'h00000020)
        else $error("sub-entry count wrong");
    chk_shift_gate: assert property (
        drive_outputs_o && $past(is_dc) && !$past(sync0_i)
        |-> osp_to_ns($past(state_reg.s0_cnt)) >= $past(state_reg.shift))
        else $error("outputs driven before shift elapsed");
    chk_start_clear: assert property (
        start_meas |=> state_reg.min_cycle == 32'h0 && state_reg.delay == 32'h0)
        else $error("maxima not cleared on start");
    chk_missed_cnt: assert property (
        !(is_dc && op_state_i && sync0_i) |=> $stable(state_reg.missed))
        else $error("missed counter moved outside dc operational sync0");
    chk_exceed_cnt: assert property (
        trigger && op_state_i && (state_reg.pend || state_reg.busy)
        && state_reg.exceeded != 16'hffff |=> state_reg.exceeded == $past(state_reg.exceeded) + 16'h1)
        else $error("cycle exceeded not counted");
    chk_short_sat: assert property (
        state_reg.short_cnt == 16'hffff |=> state_reg.short_cnt == 16'hffff)
        else $error("shift short counter wrapped");
    chk_sync_err: assert property (
        trigger && is_dc && state_reg.pend |=> state_reg.sync_err ##1 1'b1)
        else $error("late drive not flagged");
    // a drive always raises its status bit, so an unmasked drive must show on the line
    chk_irq_level: assert property (
        drive_outputs_o && state_reg.irq_mask[OSP_IRQ_DRIVEN] |-> irq_o)
        else $error("interrupt level wrong");

    cov_drive_dc: cover property (is_dc ##1 drive_outputs_o);
    cov_late: cover property (trigger && state_reg.pend && is_dc);
    cov_measure: cover property (start_meas ##[1:50] cycle_done_i);
    cov_short: cover property (sync1_i && is_dc && osp_to_ns(state_reg.s0_cnt) < state_reg.calc_copy);
endmodule

// *** osp_event_src.sv ***
// event source model standing in for the device core and the sync unit
`timescale 1ns/1ps
module osp_event_src (
    // clock
    input wire logic clk_i,
    // requests from the bench, one bit per event
    input wire logic [5:0] req_i,
    // pulses: sm event, sync0, sync1, cycle done, input latch, input ready
    output logic [5:0] ev_o
);
    // events leave on the edge after the request, as the sync unit would issue them;
    // a request held for one cycle gives exactly one pulse, so the bank counts it once
    always @(posedge clk_i)
    begin
        ev_o <= req_i;
    end
endmodule

// *** osp_bank_tb.sv ***
// self-checking bench for the output synchronisation parameter bank
`timescale 1ns/1ps
module osp_bank_tb;
    import osp_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [5:0] addr_i = 6'h00;
    logic [31:0] wr_data_i = 32'h0;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic op_state_i = 1'b0;
    logic [31:0] rd_data_o;
    logic drive_outputs_o;
    logic irq_o;
    logic [5:0] ev;
    logic [31:0] rv;
    logic [5:0] ev_req = 6'h00;
    logic [5:0] ra;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    osp_event_src i_src (.clk_i(clk_i), .req_i(ev_req), .ev_o(ev));

    osp_bank i_dut (
        .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
        .sm_event_i(ev[0]), .sync0_i(ev[1]), .sync1_i(ev[2]), .op_state_i(op_state_i),
        .cycle_done_i(ev[3]), .input_latch_i(ev[4]), .input_ready_i(ev[5]),
        .drive_outputs_o(drive_outputs_o), .irq_o(irq_o)
    );

    // verdict and end of run
    task automatic wrap_up();
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // a hang is cut short well beyond the few hundred cycles the tests need
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    // register writes are one strobed cycle; the bank never stalls
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_en_i <= 1'b1;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge clk_i);
        rd_en_i <= 1'b0;
        #1 d = rd_data_o;
    endtask

    task automatic chk_val(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic chk_rd(input logic [5:0] a, input logic [31:0] exp);
        rd(a, rv);
        chk_val(exp, rv);
    endtask

    task automatic chk_true(input logic c);
        checks++;
        if (c !== 1'b1)
        begin
            miscompares++;
            $display("wrong value at %0t: condition not met", $time);
        end
    endtask

    // bounded wait for one drive pulse; it stands a single cycle
    task automatic wait_drive();
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 40 && !seen; i++)
        begin
            @(posedge clk_i);
            #1 seen = (drive_outputs_o === 1'b1);
        end
        chk_true(seen);
    endtask

    // registered outputs follow a write on the edge it lands; two edges leave margin
    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    // reset image of every index; unmapped ones read zero
    function automatic logic [31:0] exp_reset(input logic [5:0] a);
        case (a)
            OSP_IDX_PARAM_COUNT: return 32'h20;
            OSP_IDX_CAPAB: return 32'h8007;
            OSP_IDX_IN_ASSIGN_CNT: return 32'h1;
            OSP_IDX_IN_ASSIGN_ENTRY: return 32'h1a01;
            default: return 32'h0;
        endcase
    endfunction

    // writable places picked by a random number
    function automatic logic [5:0] rw_idx(input int k);
        case (k)
            0: return OSP_IDX_MODE;
            1: return OSP_IDX_CYCLE;
            2: return OSP_IDX_SHIFT;
            3: return OSP_IDX_IN_ASSIGN_CNT;
            4: return OSP_IDX_IN_ASSIGN_ENTRY;
            default: return OSP_IDX_IRQ_MASK;
        endcase
    endfunction

    // what a writable place keeps of a written word; narrow ones read upper bits zero
    function automatic logic [31:0] exp_rw(input logic [5:0] a, input logic [31:0] d);
        case (a)
            OSP_IDX_MODE: return {16'h0, d[15:0]};
            OSP_IDX_IN_ASSIGN_CNT: return {24'h0, d[7:0]};
            OSP_IDX_IN_ASSIGN_ENTRY: return {16'h0, d[15:0]};
            OSP_IDX_IRQ_MASK: return {27'h0, d[4:0]};
            default: return d;
        endcase
    endfunction

    // one-cycle request launched after an edge; the source turns it into one pulse
    task automatic pulse(input int which);
        @(posedge clk_i);
        ev_req <= 6'h01 << which;
        @(posedge clk_i);
        ev_req <= 6'h00;
    endtask

    // trigger, then report the cycle computed after a latency
    task automatic fire(input int which, input int lat);
        pulse(which);
        repeat (lat) @(posedge clk_i);
        pulse(3);
    endtask

    // main sequence
    initial
    begin
        rv = $urandom(32'hdb3d);
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int a = 0; a < 64; a++)
            chk_rd(6'(a), exp_reset(6'(a)));
        // random writes: read-only places keep their values
        rv = $urandom;
        wr(OSP_IDX_CAPAB, rv);
        wr(OSP_IDX_PARAM_COUNT, rv);
        wr(OSP_IDX_MIN_CYCLE, rv);
        chk_rd(OSP_IDX_CAPAB, 32'h8007);
        chk_rd(OSP_IDX_PARAM_COUNT, 32'h20);
        chk_rd(OSP_IDX_MIN_CYCLE, 32'h0);
        wr(OSP_IDX_IN_ASSIGN_ENTRY, {16'h0, rv[15:0]});
        chk_rd(OSP_IDX_IN_ASSIGN_ENTRY, {16'h0, rv[15:0]});
        wr(OSP_IDX_CYCLE, rv);
        chk_rd(OSP_IDX_CYCLE, rv);
        // random traffic on the writable places, read back through the port
        for (int n = 0; n < 24; n++)
        begin
            rv = $urandom;
            ra = rw_idx($urandom_range(5, 0));
            wr(ra, rv);
            chk_rd(ra, exp_rw(ra, rv));
        end
        // a random shift would hold DC outputs back longer than the bench waits
        wr(OSP_IDX_SHIFT, 32'h0);
        // every mode: its own trigger leads to a drive; free run ticks every 20 cycles
        wr(OSP_IDX_CYCLE, 32'h64);
        wr(OSP_IDX_IRQ_MASK, 32'h10);
        for (int m = 0; m < 4; m++)
        begin
            wr(OSP_IDX_MODE, 32'(m));
            chk_rd(OSP_IDX_MODE, 32'(m));
            if (m == 0)
                repeat (30) @(posedge clk_i);
            // free run: a second done covers a timer tick landing on the first one
            fork
                if (m == 0) fire(3, 2); else fire(m - 1, 2);
                wait_drive();
            join
        end
        // interrupt raised, masked, cleared
        settle();
        chk_true(irq_o);
        wr(OSP_IDX_IRQ_MASK, 32'h0);
        settle();
        chk_true(irq_o === 1'b0);
        wr(OSP_IDX_IRQ_MASK, 32'h1f);
        wr(OSP_IDX_IRQ_STATUS, 32'h1f);
        chk_rd(OSP_IDX_IRQ_STATUS, 32'h0);
        chk_true(irq_o === 1'b0);
        // second trigger before the cycle finished, operational
        @(posedge clk_i);
        op_state_i <= 1'b1;
        wr(OSP_IDX_MODE, 32'h1);
        pulse(0);
        pulse(0);
        fork pulse(3); wait_drive(); join
        chk_rd(OSP_IDX_EXCEEDED, 32'h1);
        // sync0 twice with no sm event between counts one miss
        wr(OSP_IDX_MODE, 32'h2);
        pulse(0);
        fork fire(1, 2); wait_drive(); join
        pulse(1);
        fork pulse(3); wait_drive(); join
        chk_rd(OSP_IDX_MISSED, 32'h1);
        chk_rd(OSP_IDX_SYNC_ERR, 32'h0);
        // sync0 again while outputs still pending: late outputs
        pulse(0);
        pulse(1);
        pulse(1);
        chk_rd(OSP_IDX_SYNC_ERR, 32'h1);
        chk_rd(OSP_IDX_EXCEEDED, 32'h2);
        fork pulse(3); wait_drive(); join
        chk_rd(OSP_IDX_SYNC_ERR, 32'h0);
        // measurement of maxima, outside the operational state
        @(posedge clk_i);
        op_state_i <= 1'b0;
        wr(OSP_IDX_COMMAND, 32'h1);
        chk_rd(OSP_IDX_COMMAND, 32'h1);
        pulse(1);
        repeat (8) @(posedge clk_i);
        pulse(2);
        pulse(4);
        pulse(5);
        fork pulse(3); wait_drive(); join
        wr(OSP_IDX_COMMAND, 32'h0);
        rd(OSP_IDX_CALC_COPY, rv);
        chk_true(rv >= 32'h28);
        rd(OSP_IDX_MIN_CYCLE, rv);
        chk_true(rv >= 32'h28);
        rd(OSP_IDX_DELAY, rv);
        chk_true(rv != 32'h0);
        // input set: latch comes after sync1, which is at least 40 ns after sync0
        rd(OSP_IDX_IN_SHIFT, rv);
        chk_true(rv >= 32'h28);
        rd(OSP_IDX_IN_DELAY, rv);
        chk_true(rv != 32'h0);
        rd(OSP_IDX_IN_CALC_COPY, rv);
        chk_true(rv != 32'h0);
        // sync1 closer to sync0 than the recorded minimum spacing
        pulse(1);
        pulse(2);
        fork pulse(3); wait_drive(); join
        chk_rd(OSP_IDX_SHORT, 32'h1);
        // a fresh start forgets the old maxima
        wr(OSP_IDX_COMMAND, 32'h1);
        chk_rd(OSP_IDX_CALC_COPY, 32'h0);
        chk_rd(OSP_IDX_MIN_CYCLE, 32'h0);
        chk_rd(OSP_IDX_DELAY, 32'h0);
        chk_rd(OSP_IDX_IN_SHIFT, 32'h0);
        wrap_up();
    end
endmodule
